// ### rtl/pnp_pkg.sv
package pnp_pkg;
   // management address and width of the captured partner word
   localparam int         ADDR_W              = 5;
   localparam int         WORD_W              = 16;
   localparam logic [4:0] PARTNER_NP_OFFSET   = 5'h08;
   localparam logic [15:0] PARTNER_NP_RESET   = 16'h0000;
   // field positions inside the captured word
   localparam int         NEXT_PAGE_BIT       = 15;
   localparam int         ACK_BIT             = 14;
   localparam int         MSG_PAGE_BIT        = 13;
   localparam int         ACK2_BIT            = 12;
   localparam int         TOGGLE_BIT          = 11;
   localparam int         CODE_MSB            = 10;
   localparam int         CODE_LSB            = 0;
   localparam logic [15:0] UNMAPPED_READ      = 16'h0000;
endpackage

// ### rtl/pnp_partner_next_page.sv
// Contract
// RQ1: bit 15 holds partner next-page flag
// RQ2: bit 14 holds partner acknowledge flag
// RQ3: bit 13 marks message versus unformatted page
// RQ4: bit 12 holds partner comply flag
// RQ5: bit 11 holds captured toggle bit
// RQ6: bits 10-0 hold the page code
// RQ7: word at offset 0x8, reset zero
// RQ8: read-only, updates only on new page
`timescale 1ns/1ps
`default_nettype none
module pnp_partner_next_page (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // capture side from the arbitration logic, same clock
   input  wire logic                        page_rx_valid,
   input  wire logic                        rx_next_page,
   input  wire logic                        rx_ack,
   input  wire logic                        rx_msg_page,
   input  wire logic                        rx_ack2,
   input  wire logic                        rx_toggle,
   input  wire logic [10:0]                 rx_code,
   // management side
   input  wire logic                        mgmt_rd,
   input  wire logic                        mgmt_wr,
   input  wire logic [pnp_pkg::ADDR_W-1:0]  mgmt_addr,
   input  wire logic [pnp_pkg::WORD_W-1:0]  mgmt_wdata,
   output logic      [pnp_pkg::WORD_W-1:0]  mgmt_rdata,
   output logic                             mgmt_rvalid
);
   import pnp_pkg::*;

   // width of the page code field, taken from its bit positions
   localparam int CODE_W = CODE_MSB - CODE_LSB + 1;

   // one register per field of the captured partner page
   logic              next_page_ff;
   logic              nxt_next_page;
   logic              ack_ff;
   logic              nxt_ack;
   logic              msg_page_ff;
   logic              nxt_msg_page;
   logic              ack2_ff;
   logic              nxt_ack2;
   logic              toggle_ff;
   logic              nxt_toggle;
   logic [CODE_W-1:0] code_ff;
   logic [CODE_W-1:0] nxt_code;

   // a fresh page from the arbitration logic
   logic              capture;

   // the field registers put back together in register order
   logic [WORD_W-1:0] word_view;

   // management read path
   logic              hit_word;
   logic              rd_hit;
   logic              rd_miss;
   logic [WORD_W-1:0] nxt_rdata;
   logic [WORD_W-1:0] rdata_ff;
   logic              nxt_rvalid;
   logic              rvalid_ff;

   // write side, accepted on the bus but never stored
   logic              wr_seen;
   logic              unused_wr;

   // every field is taken on the same strobe; updating fields one by one
   // could leave software reading a mix of two different pages
   assign capture = page_rx_valid;  // see RQ8

   // next-page flag: one means the partner has further pages queued
   assign nxt_next_page = capture ? rx_next_page : next_page_ff;  // see RQ1

   // acknowledge: one means the partner saw our local code word
   assign nxt_ack = capture ? rx_ack : ack_ff;  // see RQ2

   // page type: one for a message page, zero for an unformatted page
   assign nxt_msg_page = capture ? rx_msg_page : msg_page_ff;  // see RQ3

   // second acknowledge: one means the partner will comply
   assign nxt_ack2 = capture ? rx_ack2 : ack2_ff;  // see RQ4

   // toggle arrives already inverted from the arbiter, so it is stored as is;
   // inverting here again would break next-page synchronisation
   assign nxt_toggle = capture ? rx_toggle : toggle_ff;  // see RQ5

   // page code: message code or unformatted content, decided by software
   assign nxt_code = capture ? rx_code : code_ff;  // see RQ6

   // next-page flag register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         next_page_ff <= PARTNER_NP_RESET[NEXT_PAGE_BIT];  // see RQ7
      end else begin
         next_page_ff <= nxt_next_page;
      end
   end

   // acknowledge register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_ff <= PARTNER_NP_RESET[ACK_BIT];  // see RQ7
      end else begin
         ack_ff <= nxt_ack;
      end
   end

   // page type register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         msg_page_ff <= PARTNER_NP_RESET[MSG_PAGE_BIT];  // see RQ7
      end else begin
         msg_page_ff <= nxt_msg_page;
      end
   end

   // second acknowledge register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack2_ff <= PARTNER_NP_RESET[ACK2_BIT];  // see RQ7
      end else begin
         ack2_ff <= nxt_ack2;
      end
   end

   // toggle register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         toggle_ff <= PARTNER_NP_RESET[TOGGLE_BIT];  // see RQ7
      end else begin
         toggle_ff <= nxt_toggle;
      end
   end

   // page code register, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code_ff <= PARTNER_NP_RESET[CODE_MSB:CODE_LSB];  // see RQ7
      end else begin
         code_ff <= nxt_code;
      end
   end

   // fields placed at their positions in the readable word
   assign word_view[NEXT_PAGE_BIT]     = next_page_ff;  // see RQ1
   assign word_view[ACK_BIT]           = ack_ff;        // see RQ2
   assign word_view[MSG_PAGE_BIT]      = msg_page_ff;   // see RQ3
   assign word_view[ACK2_BIT]          = ack2_ff;       // see RQ4
   assign word_view[TOGGLE_BIT]        = toggle_ff;     // see RQ5
   assign word_view[CODE_MSB:CODE_LSB] = code_ff;       // see RQ6

   // address decode for the single register of this block
   assign hit_word = (mgmt_addr == PARTNER_NP_OFFSET);  // see RQ7
   assign rd_hit   = mgmt_rd & hit_word;
   assign rd_miss  = mgmt_rd & ~hit_word;

   // read data selection; the word comes from the registers, so a read and
   // a capture in the same cycle return the old page, never a torn one;
   // unmapped reads return zero so software sees no stale data
   assign nxt_rdata = rd_hit  ? word_view :
                      rd_miss ? UNMAPPED_READ :
                                rdata_ff;

   // every read strobe is answered exactly once
   assign nxt_rvalid = mgmt_rd;

   // read data register, holds until the next read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= UNMAPPED_READ;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // read answer strobe, one cycle after the request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= nxt_rvalid;
      end
   end

   // outputs straight from their registers
   assign mgmt_rdata  = rdata_ff;
   assign mgmt_rvalid = rvalid_ff;

   // the write port exists only for bus symmetry; the word is read-only,
   // so its strobe and data are folded into an unused net and dropped
   assign wr_seen   = mgmt_wr;                  // see RQ8
   assign unused_wr = wr_seen ^ (^mgmt_wdata);  // limitation: no error flag for refused writes
endmodule
`default_nettype wire

// ### test/pnp_partner_next_page_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pnp_partner_next_page_properties(input wire logic clk, rst_n, page_rx_valid, rx_next_page, rx_ack,
 rx_msg_page, rx_ack2, rx_toggle, mgmt_rd, mgmt_rvalid, input wire logic [10:0] rx_code,
 input wire logic [4:0] mgmt_addr, input wire logic [15:0] mgmt_rdata);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // fields as the word should hold them
   wire logic [15:0] w = {rx_next_page, rx_ack, rx_msg_page, rx_ack2, rx_toggle, rx_code};
   property p_cap; page_rx_valid ##1 (mgmt_rd && mgmt_addr == 5'h08 && !page_rx_valid) |=> mgmt_rdata == $past(w, 2);
   endproperty
   a_cap: assert property (p_cap) else $error("captured word wrong");
   property p_code; page_rx_valid ##1 (mgmt_rd && mgmt_addr == 5'h08 && !page_rx_valid) |=>
      mgmt_rdata[10:0] == $past(rx_code, 2); endproperty
   a_code: assert property (p_code) else $error("captured code wrong");
   property p_lat; mgmt_rd |=> mgmt_rvalid; endproperty
   a_lat: assert property (p_lat) else $error("read not answered");
   property p_one; !mgmt_rd |=> !mgmt_rvalid; endproperty
   a_one: assert property (p_one) else $error("stray read valid");
   property p_unm; mgmt_rd && mgmt_addr != 5'h08 |=> mgmt_rdata == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_hold; !mgmt_rd |=> $stable(mgmt_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   cover property (page_rx_valid ##2 mgmt_rvalid);
   cover property (mgmt_rd && mgmt_addr != 5'h08);
   cover property (mgmt_rvalid && mgmt_rdata[15]);
endmodule
bind pnp_partner_next_page pnp_partner_next_page_properties i_pnp_partner_next_page_properties (.*);
`default_nettype wire

// ### test/pnp_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pnp_link_partner(input wire logic clk, go, input wire logic [15:0] pg, output logic v = 1'b0,
 output logic [15:0] f = 16'h0000);
   // one-cycle page; between pages the fields keep changing so stale values never pass
   always_ff @(posedge clk) begin v <= go; f <= go ? pg : ~f; end
endmodule
`default_nettype wire

// ### test/pnp_partner_next_page_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module pnp_partner_next_page_tb;
   import pnp_pkg::*;
   logic clk = 0, rst_n = 0, go = 0, rd = 0, wr = 0, v, rv;
   logic [4:0] a = 0;
   logic [15:0] pg = 0, f, rdat;
   int num_errors = 0, num_checks = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   pnp_link_partner i_pnp_link_partner(.clk(clk), .go(go), .pg(pg), .v(v), .f(f));
   pnp_partner_next_page i_pnp_partner_next_page(.clk(clk), .rst_n(rst_n), .page_rx_valid(v), .rx_next_page(f[15]),
      .rx_ack(f[14]), .rx_msg_page(f[13]), .rx_ack2(f[12]), .rx_toggle(f[11]), .rx_code(f[10:0]), .mgmt_rd(rd),
      .mgmt_wr(wr), .mgmt_addr(a), .mgmt_wdata(~pg), .mgmt_rdata(rdat), .mgmt_rvalid(rv));
   task automatic rdc(input logic [4:0] ad, input logic [15:0] e);
      @(posedge clk) begin rd <= 1; a <= ad; end
      @(posedge clk) rd <= 0;
      #1 `CHK("rdata", e, rdat) `CHK("rvalid", 1'b1, rv)
   endtask
   task automatic pgs(input logic [15:0] w);
      @(posedge clk) begin go <= 1; pg <= w; end
      @(posedge clk) go <= 0;
   endtask
   task stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a hang costs a mismatch instead of an endless run
   always @(posedge clk) if (++cyc > 600) begin num_errors++; stop_test; end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      rdc(PARTNER_NP_OFFSET, 16'h0000);
      for (int i = 0; i < 16; i++) begin pgs(16'h0001 << i); rdc(PARTNER_NP_OFFSET, 16'h0001 << i); end
      @(posedge clk) begin wr <= 1; a <= PARTNER_NP_OFFSET; end
      @(posedge clk) wr <= 0;
      rdc(PARTNER_NP_OFFSET, 16'h8000);
      rdc(5'h09, 16'h0000);
      stop_test;
   end
endmodule
`default_nettype wire
